// ---- verilog/dds_serial_device.sv ----
// Synthesizer end: serial word capture, control decode, tuning registers
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module dds_serial_device
  import dds_link_pkg::*;
(
  input  wire logic        clk_sys,      // Master clock
  input  wire logic        arst_n,       // Async reset, active low
  dds_link_if.device       link,         // Serial link and pins
  output logic      [27:0] freq_word,    // Active tuning word
  output logic      [11:0] phase_word,   // Active phase offset
  output logic             dds_clear,    // Core held cleared
  output logic      [15:0] control_word, // Current control register
  output logic             word_strobe   // One pulse per word taken
);

  // Merge a 14-bit payload into one half of a tuning word
  function automatic logic [27:0] merge_half(
    input logic [27:0] old_word,
    input logic [13:0] payload,
    input logic        high_half
  );
    logic [27:0] res;
    res = high_half ? {payload, old_word[13:0]}
                    : {old_word[27:14], payload};
    return res;
  endfunction : merge_half

  // Next value of a tuning word for one serial write to it
  function automatic logic [27:0] tune_next(
    input logic [27:0] old_word,
    input logic [13:0] payload,
    input logic        full_mode,
    input logic        half_pick,
    input logic        pair_done,
    input logic [13:0] low_part
  );
    logic [27:0] res;
    if (!full_mode) begin
      res = merge_half(old_word, payload, half_pick);
    end else if (pair_done) begin
      res = {payload, low_part};
    end else begin
      res = old_word;
    end
    return res;
  endfunction : tune_next

  // Synchronised link levels
  logic [5:0]  raw_pins;      // Pins as they arrive
  logic [5:0]  sync_pins;     // After two flops
  logic        sclk_s;        // Shift clock level
  logic        frame_n_s;     // Frame sync level
  logic        sdata_s;       // Serial data level
  logic        fpin_s;        // Frequency pick pin
  logic        ppin_s;        // Phase pick pin
  logic        cpin_s;        // Clear pin

  // Capture state
  logic        sclk_prev_reg; // Shift clock one cycle ago
  logic [3:0]  bit_cnt_reg;   // Bits taken in current word
  logic [14:0] shift_reg;     // Bits collected so far
  logic        sclk_fall;     // Falling edge seen this cycle
  logic        word_done;     // Sixteenth bit arrives now
  logic [15:0] new_word;      // Completed word

  // Register file
  logic [13:0] ctrl_reg;      // Control bits
  logic [27:0] freq_a_reg;    // tuning_word_a
  logic [27:0] freq_b_reg;    // tuning_word_b
  logic [11:0] phase_a_reg;   // phase_offset_a
  logic [11:0] phase_b_reg;   // phase_offset_b
  logic        low_valid_reg; // Low half of a full load waiting
  logic        low_addr_reg;  // Waiting half belongs to word B
  logic [13:0] low_data_reg;  // Waiting low half

  // Decode
  logic [1:0]  prefix;        // Address prefix
  logic [13:0] payload;       // Lower fourteen bits
  logic        wr_ctrl;       // Control write
  logic        wr_a;          // Write to tuning_word_a
  logic        wr_b;          // Write to tuning_word_b
  logic        wr_ph;         // Write to a phase offset
  logic        full_mode;     // full_word_load
  logic        half_select;   // half_select
  logic        pair_a;        // Completes a full load of A
  logic        pair_b;        // Completes a full load of B
  logic [27:0] freq_a_next;   // Next tuning_word_a
  logic [27:0] freq_b_next;   // Next tuning_word_b

  // Selection and latency pipe
  logic        pins_rule;     // Pins govern selection and clear
  logic        sel_freq;      // Effective frequency pick
  logic        sel_phase;     // Effective phase pick
  logic        sel_clear;     // Effective clear
  logic [27:0] pipe_freq_reg  [PIPE_LEN];  // Delayed tuning word
  logic [11:0] pipe_phase_reg [PIPE_LEN];  // Delayed phase offset
  logic        pipe_clear_reg [PIPE_LEN];  // Delayed clear

  // Every link level crosses through two flops before use
  assign raw_pins = {link.sclk, link.frame_sync_n, link.sdata,
                     link.freq_pick_pin, link.phase_pick_pin,
                     link.clear_pin};
  sync_2ff u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     (raw_pins),
    .dout    (sync_pins)
  );
  assign {sclk_s, frame_n_s, sdata_s, fpin_s, ppin_s, cpin_s} = sync_pins;

  // Edge finder; shift clock must already be high as the frame opens
  assign sclk_fall = sclk_prev_reg & ~sclk_s;
  assign word_done = ~frame_n_s & sclk_fall & (bit_cnt_reg == LAST_BIT);
  assign new_word  = {shift_reg, sdata_s};

  // Shift one bit per falling edge inside a frame; counter wraps
  // so a long frame carries many words
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_reg <= 1'b1;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 15'h0000;
    end else begin
      sclk_prev_reg <= sclk_s;
      if (frame_n_s) begin
        bit_cnt_reg <= 4'h0;
      end else if (sclk_fall) begin
        shift_reg   <= {shift_reg[13:0], sdata_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  // Address and mode decode
  assign prefix      = new_word[15:14];
  assign payload     = new_word[13:0];
  assign wr_ctrl     = word_done & (prefix == PFX_CTRL);
  assign wr_a        = word_done & (prefix == PFX_FREQ_A);
  assign wr_b        = word_done & (prefix == PFX_FREQ_B);
  assign wr_ph       = word_done & (prefix == PFX_PHASE);
  assign full_mode   = ctrl_reg[FULL_BIT];
  assign half_select = ctrl_reg[HALF_BIT];
  // The second write of a pair must name the same word as the first
  assign pair_a      = low_valid_reg & ~low_addr_reg;
  assign pair_b      = low_valid_reg & low_addr_reg;
  // Full mode keeps the old word until both halves exist
  assign freq_a_next = tune_next(freq_a_reg, payload, full_mode,
                                 half_select, pair_a, low_data_reg);
  assign freq_b_next = tune_next(freq_b_reg, payload, full_mode,
                                 half_select, pair_b, low_data_reg);

  // Control and tuning registers in the master-clock domain
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg      <= CTRL_RESET[13:0];
      freq_a_reg    <= 28'h0000000;
      freq_b_reg    <= 28'h0000000;
      phase_a_reg   <= 12'h000;
      phase_b_reg   <= 12'h000;
      low_valid_reg <= 1'b0;
      low_addr_reg  <= 1'b0;
      low_data_reg  <= 14'h0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg      <= payload;
        low_valid_reg <= 1'b0;     // Any control write drops a lone half
      end
      if (wr_a) begin
        freq_a_reg <= freq_a_next;
      end
      if (wr_b) begin
        freq_b_reg <= freq_b_next;
      end
      // Pair tracking; a third write to one word starts a new pair
      if ((wr_a | wr_b) & full_mode) begin
        if (low_valid_reg & (low_addr_reg == wr_b)) begin
          low_valid_reg <= 1'b0;
        end else begin
          low_valid_reg <= 1'b1;
          low_addr_reg  <= wr_b;
          low_data_reg  <= payload;
        end
      end
      if (wr_ph & ~payload[PHASE_SEL_BIT]) begin
        phase_a_reg <= payload[11:0];
      end
      if (wr_ph & payload[PHASE_SEL_BIT]) begin
        phase_b_reg <= payload[11:0];
      end
    end
  end

  // Pins or control bits govern selection and clear
  assign pins_rule = ctrl_reg[SRC_BIT];
  assign sel_freq  = pins_rule ? fpin_s : ctrl_reg[FREQ_PICK_BIT_BIT];
  assign sel_phase = pins_rule ? ppin_s : ctrl_reg[PSEL_BIT];
  assign sel_clear = pins_rule ? cpin_s : ctrl_reg[CLEAR_BIT];

  // Fixed pipe: any change of selection or selected word needs the
  // full latency; costs flops but gives a deterministic delay
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < PIPE_LEN; i++) begin
        pipe_freq_reg[i]  <= 28'h0000000;
        pipe_phase_reg[i] <= 12'h000;
        pipe_clear_reg[i] <= 1'b0;
      end
    end else begin
      pipe_freq_reg[0]  <= sel_freq ? freq_b_reg : freq_a_reg;
      pipe_phase_reg[0] <= sel_phase ? phase_b_reg : phase_a_reg;
      pipe_clear_reg[0] <= sel_clear;
      for (int i = 1; i < PIPE_LEN; i++) begin
        pipe_freq_reg[i]  <= pipe_freq_reg[i-1];
        pipe_phase_reg[i] <= pipe_phase_reg[i-1];
        pipe_clear_reg[i] <= pipe_clear_reg[i-1];
      end
    end
  end

  // Output flops; clear forces the midscale (zero) state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      freq_word   <= 28'h0000000;
      phase_word  <= 12'h000;
      dds_clear   <= 1'b0;
      word_strobe <= 1'b0;
    end else begin
      if (pipe_clear_reg[PIPE_LEN-1]) begin
        freq_word  <= 28'h0000000;
        phase_word <= 12'h000;
      end else begin
        freq_word  <= pipe_freq_reg[PIPE_LEN-1];
        phase_word <= pipe_phase_reg[PIPE_LEN-1];
      end
      dds_clear   <= pipe_clear_reg[PIPE_LEN-1];
      word_strobe <= word_done;
    end
  end

  // Control register read-out with the control prefix on top
  assign control_word = {PFX_CTRL, ctrl_reg};

endmodule : dds_serial_device

// ---- verilog/dds_link_pkg.sv ----
// Shared constants for the serial tuning link and its two ends
package dds_link_pkg;
  // Serial word geometry
  localparam int WORD_BITS = 16;             // Bits per serial word
  localparam logic [3:0] LAST_BIT = 4'hF;    // Index of the sixteenth bit
  localparam int HALF_BITS = 14;             // Payload bits per word
  localparam int TUNE_BITS = 28;             // Full tuning word width
  localparam int PHASE_BITS = 12;            // Phase offset width
  // Address prefix in the two top bits
  localparam logic [1:0] PFX_CTRL   = 2'h0;  // Control write
  localparam logic [1:0] PFX_FREQ_A = 2'h1;  // Tuning word A
  localparam logic [1:0] PFX_FREQ_B = 2'h2;  // Tuning word B
  localparam logic [1:0] PFX_PHASE  = 2'h3;  // Phase offset A or B
  localparam int PHASE_SEL_BIT = 13;         // Picks phase offset B
  // Control word field positions
  localparam int FULL_BIT  = 13;             // full_word_load
  localparam int HALF_BIT  = 12;             // half_select
  localparam int FREQ_PICK_BIT_BIT  = 11;             // freq_pick_bit
  localparam int PSEL_BIT  = 10;             // phase pick bit
  localparam int SRC_BIT   = 9;              // control_source
  localparam int CLEAR_BIT = 8;              // Internal clear
  localparam logic [15:0] CTRL_RESET = 16'h0000; // Control reset value
  // Selection and load latency in master-clock cycles
  localparam int LATENCY_CYC = 8;
  localparam int PIPE_LEN = LATENCY_CYC - 1; // Stages before output flop
  // Host timing: shift clock half period
  localparam int CLK_NS = 8;                 // clk_sys period
  localparam int SCLK_HALF_NS = 64;          // Shift clock half period
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] HALF_LOAD = 4'(SCLK_HALF_CYC - 1);
  // Host register byte offsets
  localparam logic [3:0] OFS_TX     = 4'h0;  // Word to send
  localparam logic [3:0] OFS_STATUS = 4'h4;  // Busy flag
  localparam logic [3:0] OFS_PINS   = 4'h8;  // Select and clear pins
  localparam int BUSY_BIT = 0;               // Status: frame in flight
  localparam int PIN_FREQ_BIT  = 0;          // Pins: frequency pick
  localparam int PIN_PHASE_BIT = 1;          // Pins: phase pick
  localparam int PIN_CLEAR_BIT = 2;          // Pins: internal clear
  localparam logic [2:0] PINS_RESET = 3'h0;  // Pin register reset value
endpackage : dds_link_pkg

// ---- verilog/dds_link_if.sv ----
// Serial link and select pins between controller and synthesizer
`timescale 1ns/1ps
interface dds_link_if;
  logic sclk;            // Shift clock, idles high
  logic frame_sync_n;    // Frame marker and chip enable, active low
  logic sdata;           // Serial data, MSB first
  logic freq_pick_pin;   // Tuning word select pin
  logic phase_pick_pin;  // Phase offset select pin
  logic clear_pin;       // Internal clear pin
  modport device (
    input sclk, frame_sync_n, sdata, freq_pick_pin, phase_pick_pin,
          clear_pin
  );
  modport host (
    output sclk, frame_sync_n, sdata, freq_pick_pin, phase_pick_pin,
           clear_pin
  );
endinterface : dds_link_if

// ---- verilog/sync_2ff.sv ----
// Two-flop synchroniser for a group of independent pin levels
`timescale 1ns/1ps
module sync_2ff (
  input  wire logic       clk_sys,  // Sampling clock
  input  wire logic       arst_n,   // Async reset, active low
  input  wire logic [5:0] din,      // Asynchronous levels
  output logic      [5:0] dout      // Synchronised levels
);
  logic [5:0] meta_reg;  // First stage, read only by second stage

  // Idle value: all link levels high (shift clock idles high, no frame)
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 6'h3F;
      dout     <= 6'h3F;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : sync_2ff

// ---- verilog/dds_serial_host.sv ----
// Controller end: Avalon-MM registers driving the serial tuning link
`timescale 1ns/1ps
module dds_serial_host
  import dds_link_pkg::*;
(
  input  wire logic        clk_sys,         // System clock
  input  wire logic        arst_n,          // Async reset, active low
  input  wire logic [3:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  output logic      [31:0] avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  dds_link_if.host         link             // Serial link and pins
);

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,  // Frame sync high, shift clock high
    ST_SETUP = 6'b000010,  // Frame open, first bit set up
    ST_LOW   = 6'b000100,  // Shift clock low after a falling edge
    ST_HIGH  = 6'b001000,  // Shift clock high, next bit on the wire
    ST_END   = 6'b010000,  // Last bit done, frame still open
    ST_GAP   = 6'b100000   // Frame closed, idle spacing
  } state_type;

  state_type   state_reg;      // Link sequencer state
  logic [3:0]  div_reg;        // Half-period countdown
  logic [3:0]  bit_reg;        // Index of the bit now on the wire
  logic [15:0] tx_reg;         // Word being shifted, MSB on top
  logic [15:0] last_reg;       // Last word accepted
  logic [2:0]  pins_reg;       // Select and clear pin levels
  logic        rd_ack_reg;     // Read answer cycle
  logic        tick;           // Half period elapsed
  logic        busy;           // Frame in flight
  logic        hit_tx;         // Address is the transmit register
  logic        tx_stall;       // Transmit write must wait
  logic        tx_take;        // Transmit write accepted
  logic        pins_take;      // Pin register written
  logic [31:0] rd_mux;         // Read data source

  assign tick      = (div_reg == 4'h0);
  assign busy      = (state_reg != ST_IDLE);
  assign hit_tx    = (avs_address == OFS_TX);
  // A new word waits until the current frame and its gap have ended
  assign tx_stall  = avs_write & hit_tx & busy;
  assign tx_take   = avs_write & hit_tx & ~busy;
  assign pins_take = avs_write & (avs_address == OFS_PINS);
  assign avs_waitrequest = tx_stall | (avs_read & ~rd_ack_reg);

  // Unmapped addresses read as zero
  assign rd_mux =
    (avs_address == OFS_TX)     ? {16'h0000, last_reg} :
    (avs_address == OFS_STATUS) ? {31'h00000000, busy} :
    (avs_address == OFS_PINS)   ? {29'h00000000, pins_reg} :
                                  32'h00000000;

  // Reads answer on the second cycle from a flop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_ack_reg   <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      rd_ack_reg <= avs_read & ~rd_ack_reg;
      if (avs_read & ~rd_ack_reg) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Pin register; levels go straight to the pins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pins_reg <= PINS_RESET;
      last_reg <= 16'h0000;
    end else begin
      if (pins_take) begin
        pins_reg <= avs_writedata[2:0];
      end
      if (tx_take) begin
        last_reg <= avs_writedata[15:0];
      end
    end
  end

  // Link sequencer: data changes on rising shift edges, the far end
  // samples on falling ones; frame sync opens with the clock high
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg         <= ST_IDLE;
      div_reg           <= 4'h0;
      bit_reg           <= 4'h0;
      tx_reg            <= 16'h0000;
      link.sclk         <= 1'b1;
      link.frame_sync_n <= 1'b1;
      link.sdata        <= 1'b0;
    end else begin
      div_reg <= tick ? HALF_LOAD : div_reg - 4'h1;
      unique case (state_reg)
        ST_IDLE: begin
          if (tx_take) begin
            tx_reg            <= avs_writedata[15:0];
            link.sdata        <= avs_writedata[15];
            link.frame_sync_n <= 1'b0;
            bit_reg           <= 4'h0;
            div_reg           <= HALF_LOAD;
            state_reg         <= ST_SETUP;
          end
        end
        ST_SETUP, ST_HIGH: begin
          if (tick) begin
            link.sclk <= 1'b0;
            state_reg <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (tick) begin
            link.sclk <= 1'b1;
            if (bit_reg == LAST_BIT) begin
              state_reg <= ST_END;
            end else begin
              bit_reg    <= bit_reg + 4'h1;
              tx_reg     <= {tx_reg[14:0], 1'b0};
              link.sdata <= tx_reg[14];
              state_reg  <= ST_HIGH;
            end
          end
        end
        ST_END: begin
          if (tick) begin
            link.frame_sync_n <= 1'b1;
            state_reg         <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (tick) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign link.freq_pick_pin  = pins_reg[PIN_FREQ_BIT];
  assign link.phase_pick_pin = pins_reg[PIN_PHASE_BIT];
  assign link.clear_pin      = pins_reg[PIN_CLEAR_BIT];

endmodule : dds_serial_host

// ---- tb/dds_link_properties.sv ----
// Wire checker for the serial link between the host and device ends
`timescale 1ns/1ps
module dds_link_properties (
  input wire logic clk_sys,        // Master clock
  input wire logic arst_n,         // Async reset, active low
  input wire logic sclk,           // Shift clock
  input wire logic frame_sync_n,   // Frame marker, active low
  input wire logic sdata,          // Serial data
  input wire logic freq_pick_pin,  // Tuning select pin
  input wire logic phase_pick_pin, // Phase select pin
  input wire logic clear_pin       // Clear pin
);
  logic [7:0] falls_reg;  // Shift falls seen in this frame
  logic [7:0] falls_next; // Next fall count
  logic       sclk_reg;   // Shift clock one cycle ago
  wire        fell_now;   // Falling shift edge seen
  assign fell_now = sclk_reg & ~sclk;
  // Count clears between frames so every frame is judged alone
  assign falls_next = frame_sync_n ? 8'h00 : falls_reg + {7'h00, fell_now};
  // Helper counter of falling shift edges
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      falls_reg <= 8'h00;
      sclk_reg  <= 1'b1;
    end else begin
      falls_reg <= falls_next;
      sclk_reg  <= sclk;
    end
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_frame_setup;
    $fell(frame_sync_n) |-> sclk [*8] ##1 !sclk;
  endproperty
  a_frame_setup: assert property (p_frame_setup)
    else $error("shift clock not high ahead of first fall");
  property p_idle_high;
    frame_sync_n |-> sclk;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("shift clock moved outside a frame");
  property p_low_half;
    $fell(sclk) |-> !sclk [*8] ##1 sclk;
  endproperty
  a_low_half: assert property (p_low_half)
    else $error("shift clock low half wrong length");
  property p_high_half;
    $rose(sclk) && !frame_sync_n |-> sclk [*8];
  endproperty
  a_high_half: assert property (p_high_half)
    else $error("shift clock high half too short");
  property p_data_hold;
    !sclk |-> $stable(sdata);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("serial data moved while shift clock low");
  property p_word_whole;
    $rose(frame_sync_n) |-> falls_reg == 8'h10;
  endproperty
  a_word_whole: assert property (p_word_whole)
    else $error("frame did not hold exactly one word");
  property p_frame_span;
    $fell(frame_sync_n) |-> ##[262:266] $rose(frame_sync_n);
  endproperty
  a_frame_span: assert property (p_frame_span)
    else $error("frame closed at the wrong time");
  property p_gap;
    $rose(frame_sync_n) |-> frame_sync_n [*8];
  endproperty
  a_gap: assert property (p_gap)
    else $error("frame gap too short");
endmodule : dds_link_properties

// ---- tb/test_dds_serial_control_load.sv ----
// Self-checking bench joining the host and device ends of the link
`timescale 1ns/1ps
module test_dds_serial_control_load
  import dds_link_pkg::*;
();
  logic        clk_sys       = 1'b0;  // Master clock
  logic        arst_n        = 1'b0;  // Reset, active low
  logic [3:0]  avs_address   = 4'h0;  // Bus address
  logic        avs_read      = 1'b0;  // Bus read
  logic        avs_write     = 1'b0;  // Bus write
  logic [31:0] avs_writedata = 32'h0; // Bus write data
  logic [31:0] avs_readdata;          // Bus read data
  logic        avs_waitrequest;       // Bus stall
  logic [27:0] freq_word;             // Active tuning word
  logic [11:0] phase_word;            // Active phase offset
  logic        dds_clear;             // Core held cleared
  logic [15:0] control_word;          // Device control register
  logic        word_strobe;           // One pulse per word
  logic [15:0] ctl = 16'h0;           // Expected control register
  logic [27:0] fa = 28'h0;            // Expected tuning word A
  logic [27:0] fb = 28'h0;            // Expected tuning word B
  logic [11:0] pa = 12'h0;            // Expected phase offset A
  logic [11:0] pb = 12'h0;            // Expected phase offset B
  logic [2:0]  pins = 3'h0;           // Expected pin levels
  logic        pend = 1'b0;           // Low half awaiting its pair
  logic [1:0]  pend_t = 2'h0;         // Target of that half
  logic [13:0] pend_low = 14'h0;      // Value of that half
  logic [31:0] rd;                    // Last read data
  int          errors, total_checks;  // Mismatches and comparisons
  int          strobes, words;        // Pulses seen and words sent
  int          seed = 32'hF241;       // Fixed random seed
  always #4 clk_sys = ~clk_sys;
  dds_link_if dds_link_if_inst ();
  dds_serial_host dds_serial_host_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(dds_link_if_inst.host));
  dds_serial_device dds_serial_device_inst (.clk_sys(clk_sys),
    .arst_n(arst_n), .link(dds_link_if_inst.device), .freq_word(freq_word),
    .phase_word(phase_word), .dds_clear(dds_clear),
    .control_word(control_word), .word_strobe(word_strobe));
  dds_link_properties dds_link_properties_inst (.clk_sys(clk_sys),
    .arst_n(arst_n), .sclk(dds_link_if_inst.sclk),
    .frame_sync_n(dds_link_if_inst.frame_sync_n),
    .sdata(dds_link_if_inst.sdata),
    .freq_pick_pin(dds_link_if_inst.freq_pick_pin),
    .phase_pick_pin(dds_link_if_inst.phase_pick_pin),
    .clear_pin(dds_link_if_inst.clear_pin));
  // Count word pulses from the device
  always @(posedge clk_sys) if (word_strobe === 1'b1) strobes++;
  task automatic check(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask : check
  // One bus cycle, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 4000) errors++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  // Expected selection: pins or control bits, as control_source says
  function automatic logic pick(input int pin, input int bitpos);
    return ctl[SRC_BIT] ? pins[pin] : ctl[bitpos];
  endfunction : pick
  task automatic compare();
    logic clr;
    clr = pick(PIN_CLEAR_BIT, CLEAR_BIT);
    check(32'(control_word), 32'(ctl), "control");
    check(32'(dds_clear), 32'(clr), "clear");
    check(32'(freq_word), clr ? 0 : 32'(pick(0, FREQ_PICK_BIT_BIT) ? fb : fa), "f");
    check(32'(phase_word), clr ? 0 : 32'(pick(1, PSEL_BIT) ? pb : pa), "p");
  endtask : compare
  // Reference model of one tuning write; a lone full-mode half waits
  task automatic tune(input logic [1:0] t, input logic [13:0] d);
    logic [27:0] v;
    logic        hit;
    v = (t == 2'h1) ? fa : fb;
    hit = pend && pend_t == t;
    if (!ctl[FULL_BIT]) v = ctl[HALF_BIT] ? {d, v[13:0]} : {v[27:14], d};
    else if (hit) v = {d, pend_low};
    pend = ctl[FULL_BIT] && !hit;
    pend_t = t;
    pend_low = d;
    if (t == 2'h1) fa = v;
    else fb = v;
  endtask : tune
  task automatic send(input logic [15:0] w);
    int n;
    n = 0;
    bus(1'b1, OFS_TX, 32'(w));
    bus(1'b0, OFS_STATUS, 32'h0);
    check(32'(rd[BUSY_BIT]), 32'h1, "busy");
    while (rd[BUSY_BIT] !== 1'b0 && n < 200) begin
      bus(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    if (n == 200) errors++;
    words++;
    if (w[15:14] == PFX_CTRL) ctl = {2'h0, w[13:0]};
    if (w[15:14] == PFX_CTRL) pend = 1'b0;
    if (w[15:14] == PFX_PHASE && w[13]) pb = w[11:0];
    if (w[15:14] == PFX_PHASE && !w[13]) pa = w[11:0];
    if (w[15:14] == PFX_FREQ_A || w[15:14] == PFX_FREQ_B) tune(w[15:14], w[13:0]);
    repeat (12) @(posedge clk_sys);
    compare();
  endtask : send
  // Pin change measured on the falling edge, where outputs have settled
  task automatic pin_step(input logic [2:0] p);
    logic [27:0] old;
    int          n;
    old = freq_word;
    n = 0;
    pins = p;
    bus(1'b1, OFS_PINS, 32'(p));
    while (freq_word === old && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n >= 10 && n <= 11), 32'h1, "pin latency");
    compare();
  endtask : pin_step
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // Watchdog well beyond the roughly 81 us the sequence needs
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
  initial begin
    logic [1:0] p;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    compare();
    bus(1'b0, 4'hC, 32'h0);
    check(rd, 32'h0, "unmapped");
    // Half mode: high then low half, boundary values
    send(16'h1000);
    send(16'h7FFF);
    send(16'h0000);
    send(16'h4001);
    send(16'h8ABC);
    // Full mode with half_select set, which must be ignored; then select bits, clear and pins
    send(16'h3000);
    send(16'h4555);
    send(16'h4AAA);
    send(16'h8123);
    send(16'h8FED);
    send(16'hC123);
    send(16'hEABC);
    send(16'h0C00);
    send(16'h0D00);
    send(16'h0200);
    pin_step(3'h3);
    pin_step(3'h5);
    pin_step(3'h0);
    // Random controls in half mode, each followed by a random write
    for (int i = 0; i < 10; i++) begin
      send(16'($random(seed)) & 16'h1F00);
      p = 2'($random(seed));
      send({(p == 2'h0) ? 2'h1 : p, 14'($random(seed))});
    end
    check(32'(strobes), 32'(words), "word pulses");
    tally_and_finish();
  end
endmodule : test_dds_serial_control_load
